// *** hw/tws_eeprom.sv ***
// Purpose: Two-wire bus target for a 4K or 8K bit byte-wide memory.
// Assumes: Bus pins are asynchronous and sampled by ref_clk.
// Notes: Read data is prefetched into a two-entry buffer.

`timescale 1ns/1ps

module tws_eeprom #(
   parameter bit IS_8K = 1'b1,
   parameter int unsigned WR_CYCLES = tws_pkg::PROGRAM_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic chip_select_strap_high,
   input wire logic chip_select_strap_mid,
   input wire logic chip_select_strap_low,
   output logic write_busy
);
   localparam int AW = IS_8K ? tws_pkg::ADDR_W_LARGE
                             : tws_pkg::ADDR_W_SMALL;
   localparam int DEPTH = 1 << AW;
   localparam int PA = tws_pkg::PAGE_AW;
   localparam int CW = $clog2(WR_CYCLES + 1);

   if (WR_CYCLES < 1) begin : g_chk
      $error("Program time must be at least one cycle.");
   end

   // =========================================================
   // Pin synchronisers and bus events
   // =========================================================
   logic [1:0] scl_sy;
   logic [1:0] sda_sy;
   logic [1:0] csh_sy;
   logic [1:0] csm_sy;
   logic scl_p;
   logic sda_p;

   // The lowest strap is not connected inside either variant.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         csh_sy <= 2'h0;
         csm_sy <= 2'h0;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], scl_in};
         sda_sy <= {sda_sy[0], sda_in};
         csh_sy <= {csh_sy[0], chip_select_strap_high};
         csm_sy <= {csm_sy[0], chip_select_strap_mid};
         scl_p <= scl_sy[1];
         sda_p <= sda_sy[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;

   assign scl_s = scl_sy[1];
   assign sda_s = sda_sy[1];
   assign start_ev = scl_s && scl_p && sda_p && !sda_s;
   assign stop_ev = scl_s && scl_p && !sda_p && sda_s;
   assign scl_rise = scl_s && !scl_p;
   assign scl_fall = !scl_s && scl_p;

   // =========================================================
   // Storage
   // =========================================================
   logic [7:0] mem [DEPTH];
   logic [7:0] page_data [tws_pkg::PAGE_BYTES];

   tws_pkg::tws_state_t state;
   tws_pkg::tws_state_t next_state;
   logic in_ack;
   logic next_in_ack;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] rx_sh;
   logic [7:0] next_rx_sh;
   logic [7:0] tx_sh;
   logic [7:0] next_tx_sh;
   logic m_ack;
   logic next_m_ack;
   logic rd_req;
   logic next_rd_req;
   logic [1:0] dev_page;
   logic [1:0] next_dev_page;
   logic [AW-1:0] addr_cnt;
   logic [AW-1:0] next_addr_cnt;
   logic [AW-1:0] fetch_addr;
   logic [AW-1:0] next_fetch_addr;
   logic got_data;
   logic next_got_data;
   logic [tws_pkg::PAGE_BYTES-1:0] page_mask;
   logic [tws_pkg::PAGE_BYTES-1:0] next_page_mask;
   logic [CW-1:0] wr_cnt;
   logic [CW-1:0] next_wr_cnt;
   logic next_busy;
   logic next_sda_oe;
   logic flush;
   logic commit;
   logic pd_we;
   logic load_tx;
   logic buf_pop;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [7:0] buf_out_data;
   logic [7:0] tx_byte;
   logic prefix_ok;
   logic cs_ok;

   // =========================================================
   // Read prefetch buffer
   // =========================================================
   tws_buf2 #(
      .W(tws_pkg::BYTE_BITS),
      .D(tws_pkg::BUF_DEPTH)
   ) u_buf (
      .clk(ref_clk),
      .rst(rst),
      .flush(flush),
      .in_valid(!flush),
      .in_data(mem[fetch_addr]),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(buf_pop)
   );

   // =========================================================
   // Address decode
   // =========================================================
   always_comb begin
      prefix_ok = rx_sh[tws_pkg::PREFIX_MSB:tws_pkg::PREFIX_LSB]
                  == tws_pkg::DEV_PREFIX;
      if (IS_8K) begin
         cs_ok = rx_sh[tws_pkg::CS_HIGH_BIT] == csh_sy[1];
      end else begin
         cs_ok = rx_sh[tws_pkg::CS_HIGH_BIT] == csh_sy[1]
                 && rx_sh[tws_pkg::CS_MID_BIT] == csm_sy[1];
      end
   end

   // =========================================================
   // Protocol engine and program cycle
   // =========================================================
   always_comb begin
      next_state = state;
      next_in_ack = in_ack;
      next_bit_cnt = bit_cnt;
      next_rx_sh = rx_sh;
      next_tx_sh = tx_sh;
      next_m_ack = m_ack;
      next_rd_req = rd_req;
      next_dev_page = dev_page;
      next_addr_cnt = addr_cnt;
      next_fetch_addr = fetch_addr;
      next_got_data = got_data;
      next_page_mask = page_mask;
      next_wr_cnt = wr_cnt;
      next_busy = write_busy;
      next_sda_oe = sda_oe;
      flush = 1'b0;
      commit = 1'b0;
      pd_we = 1'b0;
      load_tx = 1'b0;
      buf_pop = 1'b0;
      tx_byte = tws_pkg::IDLE_BYTE;
      if (write_busy) begin
         if (wr_cnt == CW'(1)) begin
            commit = 1'b1;
            flush = 1'b1;
            next_busy = 1'b0;
            next_page_mask = '0;
         end else begin
            next_wr_cnt = wr_cnt - 1'b1;
         end
      end
      if (start_ev) begin
         next_state = tws_pkg::TWS_DEV;
         next_in_ack = 1'b0;
         next_bit_cnt = '0;
         next_sda_oe = 1'b0;
         next_got_data = 1'b0;
         flush = 1'b1;
         next_fetch_addr = addr_cnt;
         if (!write_busy) begin
            next_page_mask = '0;
         end
      end else if (stop_ev) begin
         next_state = tws_pkg::TWS_IDLE;
         next_in_ack = 1'b0;
         next_sda_oe = 1'b0;
         if (got_data && !write_busy) begin
            next_busy = 1'b1;
            next_wr_cnt = CW'(WR_CYCLES);
         end
         next_got_data = 1'b0;
      end else begin
         unique case (state)
            tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: begin
            end
            tws_pkg::TWS_DEV, tws_pkg::TWS_WADDR,
            tws_pkg::TWS_WDATA: begin
               if (scl_rise && !in_ack) begin
                  next_rx_sh = {rx_sh[6:0], sda_s};
                  next_bit_cnt = bit_cnt + 1'b1;
               end else if (scl_fall && !in_ack
                            && bit_cnt == tws_pkg::BITS_PER_WORD) begin
                  next_in_ack = 1'b1;
                  next_sda_oe = 1'b1;
                  if (state == tws_pkg::TWS_DEV) begin
                     if (prefix_ok && cs_ok && !write_busy) begin
                        next_rd_req = rx_sh[tws_pkg::RW_BIT];
                        next_dev_page = IS_8K
                           ? rx_sh[tws_pkg::PAGE_HIGH_BIT:
                                   tws_pkg::PAGE_LOW_BIT]
                           : {1'b0, rx_sh[tws_pkg::PAGE_LOW_BIT]};
                     end else begin
                        next_state = tws_pkg::TWS_IGNORE;
                        next_in_ack = 1'b0;
                        next_sda_oe = 1'b0;
                     end
                  end else if (state == tws_pkg::TWS_WADDR) begin
                     next_addr_cnt = AW'({dev_page, rx_sh});
                     next_fetch_addr = AW'({dev_page, rx_sh});
                     flush = 1'b1;
                  end else begin
                     pd_we = 1'b1;
                     next_page_mask[addr_cnt[PA-1:0]] = 1'b1;
                     next_addr_cnt = {addr_cnt[AW-1:PA],
                        addr_cnt[PA-1:0] + 1'b1};
                     next_got_data = 1'b1;
                  end
               end else if (scl_fall && in_ack) begin
                  next_in_ack = 1'b0;
                  next_bit_cnt = '0;
                  next_sda_oe = 1'b0;
                  if (state == tws_pkg::TWS_DEV) begin
                     if (rd_req) begin
                        next_state = tws_pkg::TWS_READ;
                        load_tx = 1'b1;
                     end else begin
                        next_state = tws_pkg::TWS_WADDR;
                     end
                  end else begin
                     next_state = tws_pkg::TWS_WDATA;
                  end
               end
            end
            tws_pkg::TWS_READ: begin
               if (!in_ack) begin
                  if (scl_fall) begin
                     if (bit_cnt == tws_pkg::BITS_PER_WORD) begin
                        next_sda_oe = 1'b0;
                        next_in_ack = 1'b1;
                        next_m_ack = 1'b0;
                     end else begin
                        next_sda_oe = !tx_sh[7];
                        next_tx_sh = {tx_sh[6:0], 1'b1};
                        next_bit_cnt = bit_cnt + 1'b1;
                     end
                  end
               end else if (scl_rise) begin
                  next_m_ack = !sda_s;
               end else if (scl_fall) begin
                  next_in_ack = 1'b0;
                  if (m_ack) begin
                     load_tx = 1'b1;
                  end else begin
                     next_state = tws_pkg::TWS_IGNORE;
                  end
               end
            end
            default: begin
               next_state = tws_pkg::TWS_IDLE;
            end
         endcase
      end
      if (load_tx) begin
         buf_pop = buf_out_valid;
         if (buf_out_valid) begin
            tx_byte = buf_out_data;
            next_addr_cnt = addr_cnt + 1'b1;
         end
         next_tx_sh = {tx_byte[6:0], 1'b1};
         next_sda_oe = !tx_byte[7];
         next_bit_cnt = 4'h1;
      end
      if (!flush && buf_in_ready) begin
         next_fetch_addr = fetch_addr + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= tws_pkg::TWS_IDLE;
         in_ack <= 1'b0;
         bit_cnt <= '0;
         rx_sh <= '0;
         tx_sh <= '0;
         m_ack <= 1'b0;
         rd_req <= 1'b0;
         dev_page <= '0;
         addr_cnt <= '0;
         fetch_addr <= '0;
         got_data <= 1'b0;
         page_mask <= '0;
         wr_cnt <= '0;
         write_busy <= 1'b0;
         sda_oe <= tws_pkg::SDA_OE_RESET;
         sda_out <= tws_pkg::SDA_OUT_LEVEL;
      end else begin
         state <= next_state;
         in_ack <= next_in_ack;
         bit_cnt <= next_bit_cnt;
         rx_sh <= next_rx_sh;
         tx_sh <= next_tx_sh;
         m_ack <= next_m_ack;
         rd_req <= next_rd_req;
         dev_page <= next_dev_page;
         addr_cnt <= next_addr_cnt;
         fetch_addr <= next_fetch_addr;
         got_data <= next_got_data;
         page_mask <= next_page_mask;
         wr_cnt <= next_wr_cnt;
         write_busy <= next_busy;
         sda_oe <= next_sda_oe;
         sda_out <= tws_pkg::SDA_OUT_LEVEL;
      end
   end

   // =========================================================
   // Page latch and array commit
   // =========================================================
   always_ff @(posedge ref_clk) begin
      if (pd_we) begin
         page_data[addr_cnt[PA-1:0]] <= rx_sh;
      end
   end

   // The row stays fixed while programming since the bus is ignored.
   always_ff @(posedge ref_clk) begin
      if (commit) begin
         for (int i = 0; i < tws_pkg::PAGE_BYTES; i++) begin
            if (page_mask[i]) begin
               mem[{addr_cnt[AW-1:PA], PA'(i)}] <= page_data[i];
            end
         end
      end
   end

endmodule

// *** hw/tws_pkg.sv ***
// Purpose: Shared constants and types for the two-wire memory target.
// Assumes: A 20 MHz system clock samples the bus pins.
// Notes: Bit positions follow the device address word layout.

package tws_pkg;

   // =========================================================
   // Timing
   // =========================================================
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Longest program time of the memory, 5 ms.
   localparam int unsigned PROGRAM_TIME_NS = 5000000;
   localparam int unsigned PROGRAM_CYCLES = PROGRAM_TIME_NS / CLK_PERIOD_NS;

   // =========================================================
   // Device address word
   // =========================================================
   localparam logic [3:0] DEV_PREFIX = 4'hA;
   localparam int PREFIX_MSB = 7;
   localparam int PREFIX_LSB = 4;
   localparam int CS_HIGH_BIT = 3;
   localparam int CS_MID_BIT = 2;
   localparam int PAGE_HIGH_BIT = 2;
   localparam int PAGE_LOW_BIT = 1;
   localparam int RW_BIT = 0;

   // =========================================================
   // Array organisation
   // =========================================================
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam int PAGE_AW = 4;
   localparam int PAGE_BYTES = 16;
   localparam int ADDR_W_SMALL = 9;
   localparam int ADDR_W_LARGE = 10;
   localparam int BUF_DEPTH = 2;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   // =========================================================
   // Reset values
   // =========================================================
   localparam logic SDA_OE_RESET = 1'b0;
   localparam logic SDA_OUT_LEVEL = 1'b0;

   typedef enum logic [2:0] {
      TWS_IDLE,
      TWS_DEV,
      TWS_WADDR,
      TWS_WDATA,
      TWS_READ,
      TWS_IGNORE
   } tws_state_t;

endpackage

// *** hw/tws_buf2.sv ***
// Purpose: Small valid/ready buffer with a flush input.
// Assumes: Source and sink share one clock.
// Notes: Flush empties the buffer and wins over a push.

`timescale 1ns/1ps

module tws_buf2 #(
   parameter int W = 8,
   parameter int D = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;

   if (D < 1 || W < 1) begin : g_chk
      $error("tws_buf2 needs at least one entry of one bit.");
   end

   logic [W-1:0] store [D];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0] cnt;
   logic [PW-1:0] next_wp;
   logic [PW-1:0] next_rp;
   logic [PW:0] next_cnt;
   logic push;
   logic pop;

   assign in_ready = cnt != (PW+1)'(D);
   assign out_valid = cnt != '0;
   assign out_data = store[rp];

   always_comb begin
      push = in_valid && in_ready && !flush;
      pop = out_valid && out_ready && !flush;
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      if (flush) begin
         next_wp = '0;
         next_rp = '0;
         next_cnt = '0;
      end else begin
         if (push) begin
            next_wp = (wp == PW'(D - 1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            next_rp = (rp == PW'(D - 1)) ? '0 : rp + 1'b1;
         end
         if (push && !pop) begin
            next_cnt = cnt + 1'b1;
         end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store[wp] <= in_data;
      end
   end

endmodule

// *** tb/tws_eeprom_props.sv ***
// Purpose: Pin-level timing checks for the two-wire memory target.
// Assumes: Bus pins change just after a ref_clk edge.
// Notes: Counters give the time since the last bus clock fall, stop or rise, and the length of the program cycle.
`timescale 1ns/1ps
module tws_eeprom_props #(
   parameter int unsigned WR_CYCLES = 50
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic chip_select_strap_high,
   input wire logic chip_select_strap_mid,
   input wire logic chip_select_strap_low,
   input wire logic write_busy
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // =========================================================
   // Helper counters
   // =========================================================
   logic scl_q;
   logic sda_q;
   logic [3:0] t_fall;
   logic [3:0] t_stop;
   logic [4:0] t_high;
   int unsigned n_busy;
   always_ff @(posedge ref_clk) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (rst) begin
         t_fall <= 4'hF;
         t_stop <= 4'hF;
         t_high <= 5'h00;
         n_busy <= 0;
      end else begin
         if (scl_q && !scl_in) t_fall <= 4'h0;
         else if (t_fall != 4'hF) t_fall <= t_fall + 4'h1;
         if (scl_q && scl_in && sda_in && !sda_q) t_stop <= 4'h0;
         else if (t_stop != 4'hF) t_stop <= t_stop + 4'h1;
         if (!scl_in) t_high <= 5'h00;
         else if (t_high != 5'h1F) t_high <= t_high + 5'h01;
         n_busy <= write_busy ? n_busy + 1 : 0;
      end
   end
   // =========================================================
   // Properties
   // =========================================================
   sequence s_oe_hold;
      sda_oe [*4];
   endsequence
   sequence s_busy_run;
      write_busy [*8];
   endsequence
   a_out_low: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_busy_quiet: assert property (write_busy |-> !sda_oe)
      else $error("data line driven while programming");
   a_busy_len: assert property ($fell(write_busy) |->
      n_busy == WR_CYCLES)
      else $error("program cycle length wrong");
   a_busy_start: assert property ($rose(write_busy) |->
      t_stop inside {[4'h1:4'h8]})
      else $error("program cycle began without a stop");
   a_busy_run: assert property ($rose(write_busy) |-> s_busy_run)
      else $error("program cycle cut short");
   a_oe_hold: assert property ($rose(sda_oe) |-> s_oe_hold)
      else $error("low drive too short");
   a_oe_timing: assert property ($changed(sda_oe) |->
      t_fall inside {[4'h1:4'h7]})
      else $error("data drive changed outside clock low");
   a_idle_release: assert property (t_high > 5'h0C |-> !sda_oe)
      else $error("data line held on idle bus");
endmodule
bind tws_eeprom tws_eeprom_props #(.WR_CYCLES(WR_CYCLES)) u_tws_eeprom_props (
   .ref_clk(ref_clk),
   .rst(rst),
   .scl_in(scl_in),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe(sda_oe),
   .chip_select_strap_high(chip_select_strap_high),
   .chip_select_strap_mid(chip_select_strap_mid),
   .chip_select_strap_low(chip_select_strap_low),
   .write_busy(write_busy)
);

// *** tb/tws_master.sv ***
// Purpose: Bus master model that drives clock and data of the bus.
// Assumes: One bus clock period is eight ref_clk cycles.
// Notes: The clock stands high between frames; data is open drain.
`timescale 1ns/1ps
module tws_master (
   input wire logic ref_clk,
   input wire logic sda_w,
   output logic scl,
   output logic sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic put_bit(input logic v, output logic r);
      sda_m <= v;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = sda_w;
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic start();
      sda_m <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b1;
      tick(4);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(b[i], r);
      put_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(input logic more, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         b[i] = r;
      end
      put_bit(!more, r);
   endtask
endmodule

// *** tb/tws_eeprom_tb.sv ***
// Purpose: Self-checking bench for the two-wire memory target.
// Assumes: Both variants share one bus, with a short program cycle.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
module tws_eeprom_tb;
   localparam int unsigned WR = 200;
   logic ref_clk;
   logic rst;
   logic chip_select_strap_high;
   logic chip_select_strap_mid;
   logic chip_select_strap_low;
   logic scl;
   logic sda_m;
   logic sda_out;
   logic sda_oe;
   logic write_busy;
   logic small_strap_high;
   logic small_strap_mid;
   logic sda_out_s;
   logic sda_oe_s;
   logic write_busy_s;
   wire sda_w = sda_m & (~sda_oe | sda_out) & (~sda_oe_s | sda_out_s);
   int n_errors;
   int checked;
   logic [7:0] exp_pg [16];
   tws_eeprom #(.IS_8K(1'b1), .WR_CYCLES(WR)) u_tws_eeprom (
      .ref_clk(ref_clk),
      .rst(rst),
      .scl_in(scl),
      .sda_in(sda_w),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .chip_select_strap_high(chip_select_strap_high),
      .chip_select_strap_mid(chip_select_strap_mid),
      .chip_select_strap_low(chip_select_strap_low),
      .write_busy(write_busy)
   );
   // The small variant shares the bus; its straps keep it off every
   // address that the large one answers while the large one's high strap is 1.
   tws_eeprom #(.IS_8K(1'b0), .WR_CYCLES(WR)) u_tws_eeprom_small (
      .ref_clk(ref_clk),
      .rst(rst),
      .scl_in(scl),
      .sda_in(sda_w),
      .sda_out(sda_out_s),
      .sda_oe(sda_oe_s),
      .chip_select_strap_high(small_strap_high),
      .chip_select_strap_mid(small_strap_mid),
      .chip_select_strap_low(chip_select_strap_low),
      .write_busy(write_busy_s)
   );
   tws_master u_tws_master (
      .ref_clk(ref_clk),
      .sda_w(sda_w),
      .scl(scl),
      .sda_m(sda_m)
   );
   // =========================================================
   // Shared tasks
   // =========================================================
   task automatic chk(input string w, input logic [7:0] s,
                      input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic dev(input logic [7:0] a, output logic ak);
      u_tws_master.start();
      u_tws_master.send(a, ak);
   endtask
   // Polls until the target answers; the first poll falls in the cycle.
   task automatic poll(input logic [7:0] a);
      logic ak;
      dev(a, ak);
      chk("busy flag", {7'h00, write_busy}, 8'h01);
      chk("busy poll", {7'h00, ak}, 8'h00);
      for (int n = 0; n < 8 && !ak; n++) dev(a, ak);
      chk("poll ack", {7'h00, ak}, 8'h01);
      chk("busy end", {7'h00, write_busy}, 8'h00);
   endtask
   // =========================================================
   // Scenarios
   // =========================================================
   task automatic t_bad_addr();
      logic ak;
      dev(8'hB8, ak);
      chk("prefix nack", {7'h00, ak}, 8'h00);
      dev(8'hA0, ak);
      chk("strap nack", {7'h00, ak}, 8'h00);
      chip_select_strap_mid <= 1'b1;
      dev(8'hAC, ak);
      chk("strap ack", {7'h00, ak}, 8'h01);
      u_tws_master.send(8'h05, ak);
      u_tws_master.stop();
      u_tws_master.tick(8);
      chk("no program", {7'h00, write_busy}, 8'h00);
      chip_select_strap_high <= 1'b0;
      dev(8'hA0, ak);
      chk("zero strap ack", {7'h00, ak}, 8'h01);
      u_tws_master.stop();
      chip_select_strap_high <= 1'b1;
   endtask
   task automatic t_page();
      logic ak;
      logic [7:0] b;
      dev(8'hAA, ak);
      u_tws_master.send(8'h1E, ak);
      chk("waddr ack", {7'h00, ak}, 8'h01);
      for (int i = 0; i < 17; i++) begin
         u_tws_master.send(8'h40 + i[7:0], ak);
         chk("data ack", {7'h00, ak}, 8'h01);
         exp_pg[(14 + i) % 16] = 8'h40 + i[7:0];
      end
      u_tws_master.stop();
      poll(8'hAA);
      u_tws_master.send(8'h10, ak);
      dev(8'hAB, ak);
      chk("read ack", {7'h00, ak}, 8'h01);
      for (int i = 0; i < 16; i++) begin
         u_tws_master.recv(i < 15, b);
         chk("page byte", b, exp_pg[i]);
      end
      u_tws_master.stop();
   endtask
   task automatic t_wrap();
      logic ak;
      logic [7:0] b;
      dev(8'hAE, ak);
      u_tws_master.send(8'hFF, ak);
      u_tws_master.send(8'hC1, ak);
      u_tws_master.send(8'hC2, ak);
      u_tws_master.stop();
      poll(8'hA8);
      u_tws_master.send(8'h00, ak);
      u_tws_master.send(8'hD0, ak);
      u_tws_master.send(8'hD1, ak);
      u_tws_master.stop();
      poll(8'hAE);
      u_tws_master.send(8'hFF, ak);
      dev(8'hAF, ak);
      u_tws_master.recv(1'b1, b);
      chk("last byte", b, 8'hC1);
      u_tws_master.recv(1'b0, b);
      chk("array wrap", b, 8'hD0);
      u_tws_master.stop();
      dev(8'hA9, ak);
      u_tws_master.recv(1'b0, b);
      chk("current read", b, 8'hD1);
      u_tws_master.stop();
      dev(8'hAE, ak);
      u_tws_master.send(8'hF0, ak);
      dev(8'hAF, ak);
      u_tws_master.recv(1'b0, b);
      chk("page wrap", b, 8'hC2);
      u_tws_master.stop();
   endtask
   // Writes one byte at the same word address in both pages of the
   // small variant, then reads both back.
   task automatic t_small();
      logic ak;
      logic [7:0] b;
      for (int p = 0; p < 2; p++) begin
         dev({6'h29, p[0], 1'b0}, ak);
         chk("small ack", {7'h00, ak}, 8'h01);
         u_tws_master.send(8'h23, ak);
         u_tws_master.send(8'h11 << p, ak);
         u_tws_master.stop();
         u_tws_master.tick(8);
         chk("small busy", {7'h00, write_busy_s}, 8'h01);
         u_tws_master.tick(WR);
         chk("small done", {7'h00, write_busy_s}, 8'h00);
      end
      for (int p = 0; p < 2; p++) begin
         dev({6'h29, p[0], 1'b0}, ak);
         u_tws_master.send(8'h23, ak);
         dev({6'h29, p[0], 1'b1}, ak);
         u_tws_master.recv(1'b0, b);
         chk("small page", b, 8'h11 << p);
         u_tws_master.stop();
      end
   endtask
   // =========================================================
   // Clock, sequence and watchdog
   // =========================================================
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      rst = 1'b1;
      chip_select_strap_high = 1'b1;
      chip_select_strap_mid = 1'b0;
      chip_select_strap_low = 1'b1;
      small_strap_high = 1'b0;
      small_strap_mid = 1'b1;
      n_errors = 0;
      checked = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_bad_addr();
      t_page();
      t_wrap();
      t_small();
      stop_test();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end
endmodule
